// ### bench/pcb_bank_test.sv
// Purpose: Self-checking bench for the banked configuration registers.
// Assumes: Host model drives strobes; bank count kept at thirteen.
// Notes:   Expected values come from the register map, not the design.
`timescale 1ns/1ps
`default_nettype none
module pcb_bank_test
   import pcb_pkg::*;
;
   localparam int NDEV = 13;
   localparam logic [7:0] IX [13] = '{8'h30, 8'h60, 8'h61, 8'h62, 8'h63,
      8'h70, 8'h71, 8'h74, 8'h75, 8'hf0, 8'hfe, 8'h40, 8'h72};
   localparam logic [7:0] WV [13] = '{8'hff, 8'hab, 8'hcd, 8'h12, 8'h34,
      8'hf3, 8'hfe, 8'h07, 8'h02, 8'h5a, 8'ha5, 8'hff, 8'hff};
   localparam logic [7:0] EX [13] = '{8'h01, 8'hab, 8'hcd, 8'h12, 8'h34,
      8'h13, 8'h02, 8'h07, 8'h02, 8'h5a, 8'ha5, 8'h00, 8'h00};
   logic                clk_i     = 1'b0;
   logic                reset_n_i = 1'b0;
   logic                idx_wr, idx_rd, dat_wr, dat_rd, rvalid, ok;
   logic [7:0]          wdata, rdata, d;
   pcb_res_t [NDEV-1:0] res;
   logic [NDEV-1:0]     clk_en, pins_used;
   int                  err_count   = 0;
   int                  checks_done = 0;

   always #2 clk_i = ~clk_i;

   pcb_bank #(.NUM_DEV(NDEV)) pcb_bank_i (
      .clk_i(clk_i), .reset_n_i(reset_n_i), .idx_wr_i(idx_wr),
      .idx_rd_i(idx_rd), .dat_wr_i(dat_wr), .dat_rd_i(dat_rd),
      .wdata_i(wdata), .rdata_o(rdata), .rvalid_o(rvalid), .res_o(res),
      .clk_en_o(clk_en), .pins_used_o(pins_used));
   pcb_host pcb_host_i (
      .clk_i(clk_i), .idx_wr_o(idx_wr), .idx_rd_o(idx_rd),
      .dat_wr_o(dat_wr), .dat_rd_o(dat_rd), .wdata_o(wdata),
      .rdata_i(rdata), .rvalid_i(rvalid));

   task automatic print_verdict;
      if (err_count == 0 && checks_done > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask : print_verdict

   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      checks_done++;
      if (seen !== exp) begin
         err_count++;
         $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask : check

   task automatic rdc(input logic [7:0] idx, input logic [7:0] exp);
      pcb_host_i.rd_reg(idx, d, ok);
      if (!ok) begin
         err_count++;
         print_verdict();
      end
      check(d, exp);
   endtask : rdc

   task automatic wr(input logic [7:0] idx, input logic [7:0] v);
      pcb_host_i.wr_reg(idx, v);
   endtask : wr

   task automatic hw_reset;
      reset_n_i <= 1'b0;
      repeat (20) @(posedge clk_i);
      reset_n_i <= 1'b1;
   endtask : hw_reset

   initial begin
      hw_reset();
      rdc(8'h74, 8'h04);
      rdc(8'h60, 8'h00);
      wr(IDX_BANK_SEL, 8'h02);
      for (int i = 0; i < 13; i++) wr(IX[i], WV[i]);
      for (int i = 0; i < 13; i++) rdc(IX[i], EX[i]);
      pcb_host_i.get(1'b0, d, ok);
      check(d, 8'h72);
      check(res[2].io_base0, 16'habcd);
      check(res[2].io_base1, 16'h1234);
      check(res[2].irq_line, 4'h3);
      check(res[2].irq_wake, 1'b1);
      check(res[2].irq_level, 1'b0);
      check(res[2].irq_high, 1'b1);
      check(res[2].dma0, DMA_NONE);
      check(res[2].dma1, 3'h2);
      check({res[2].active, clk_en[2], pins_used[2]}, 3'h7);
      wr(IDX_BANK_SEL, 8'h03);
      rdc(8'h60, 8'h00);
      wr(8'h60, 8'h77);
      wr(IDX_BANK_SEL, 8'h02);
      rdc(8'h60, 8'hab);
      rdc(IDX_BANK_SEL, 8'h02);
      wr(8'h30, 8'h00);
      rdc(8'h30, 8'h00);
      check(res[2].io_base0, 16'h0000);
      check(res[2].dma0, DMA_NONE);
      check({clk_en[2], pins_used[2]}, 2'h0);
      // Bank beyond the implemented devices
      wr(IDX_BANK_SEL, 8'h0e);
      wr(8'h60, 8'hff);
      rdc(8'h60, 8'h00);
      rdc(8'h75, 8'h04);
      wr(IDX_BANK_SEL, 8'h04);
      wr(8'h60, 8'h99);
      wr(IDX_BANK_SEL, 8'h01);
      wr(8'h60, 8'h55);
      wr(8'h21, 8'h3c);
      rdc(8'h21, 8'h3c);
      rdc(IDX_GLOBAL_ONE, ID_DEFAULT);
      hw_reset();
      pcb_host_i.get(1'b0, d, ok);
      check(d, 8'h00);
      rdc(IDX_BANK_SEL, 8'h00);
      rdc(8'h21, 8'h00);
      wr(IDX_BANK_SEL, 8'h01);
      rdc(8'h60, 8'h00);
      wr(IDX_BANK_SEL, 8'h04);
      rdc(8'h60, 8'h99);
      wr(8'h21, 8'h3c);
      pcb_host_i.sw_reset();
      rdc(IDX_BANK_SEL, 8'h00);
      rdc(8'h21, 8'h00);
      wr(IDX_BANK_SEL, 8'h04);
      rdc(8'h60, 8'h00);
      print_verdict();
   end
endmodule : pcb_bank_test
`default_nettype wire

// ### bench/pcb_host.sv
// Purpose: Host model driving the index/data strobes of the bank.
// Assumes: A strobe is taken on the edge after it is raised.
// Notes:   Every access holds one strobe for one cycle, then idles.
`timescale 1ns/1ps
`default_nettype none
module pcb_host
   import pcb_pkg::*;
(
   input  wire logic       clk_i,
   output logic            idx_wr_o,
   output logic            idx_rd_o,
   output logic            dat_wr_o,
   output logic            dat_rd_o,
   output logic [7:0]      wdata_o,
   input  wire logic [7:0] rdata_i,
   input  wire logic       rvalid_i
);
   initial begin
      idx_wr_o = 1'b0;
      idx_rd_o = 1'b0;
      dat_wr_o = 1'b0;
      dat_rd_o = 1'b0;
      wdata_o  = 8'h00;
   end

   task automatic put(input logic dat, input logic [7:0] v);
      @(posedge clk_i);
      idx_wr_o <= !dat;
      dat_wr_o <= dat;
      wdata_o  <= v;
      @(posedge clk_i);
      idx_wr_o <= 1'b0;
      dat_wr_o <= 1'b0;
      // Stale write data must never look valid to the bank
      wdata_o  <= ~v;
   endtask : put

   task automatic get(input logic dat, output logic [7:0] d,
                      output logic ok);
      @(posedge clk_i);
      idx_rd_o <= !dat;
      dat_rd_o <= dat;
      @(posedge clk_i);
      idx_rd_o <= 1'b0;
      dat_rd_o <= 1'b0;
      ok = 1'b0;
      d  = 8'h00;
      repeat (4) begin
         @(negedge clk_i);
         if (!ok && rvalid_i === 1'b1) begin
            ok = 1'b1;
            d  = rdata_i;
         end
      end
   endtask : get

   task automatic wr_reg(input logic [7:0] idx, input logic [7:0] v);
      put(1'b0, idx);
      put(1'b1, v);
   endtask : wr_reg

   task automatic rd_reg(input logic [7:0] idx, output logic [7:0] d,
                         output logic ok);
      put(1'b0, idx);
      get(1'b1, d, ok);
   endtask : rd_reg

   task automatic sw_reset;
      wr_reg(IDX_GLOBAL_ONE, 8'h01 << SWRST_BIT);
   endtask : sw_reset
endmodule : pcb_host
`default_nettype wire

// ### hdl/pcb_bank.sv
// Purpose: Banked plug-and-play configuration registers behind an
//          index/data pair, one bank per logical device.
// Assumes: Host cycles arrive as one-cycle strobes synchronous to clk_i.
`timescale 1ns/1ps
`default_nettype none
module pcb_bank
   import pcb_pkg::*;
#(
   parameter int         NUM_DEV  = 13,
   parameter int         WAKE_DEV = 4,
   parameter logic [7:0] PART_ID  = ID_DEFAULT  // Arbitrary value
) (
   input  wire logic                 clk_i,
   input  wire logic                 reset_n_i,
   input  wire logic                 idx_wr_i,
   input  wire logic                 idx_rd_i,
   input  wire logic                 dat_wr_i,
   input  wire logic                 dat_rd_i,
   input  wire logic [7:0]           wdata_i,
   output logic      [7:0]           rdata_o,
   output logic                      rvalid_o,
   output pcb_res_t  [NUM_DEV-1:0]   res_o,
   output logic      [NUM_DEV-1:0]   clk_en_o,
   output logic      [NUM_DEV-1:0]   pins_used_o
);
   localparam int VW = $clog2(VENDOR_REGS);

   logic [7:0] index_r;
   logic [7:0] bank_r;
   logic [7:0] gcfg_r [8];
   logic [7:0] act_r [NUM_DEV];
   logic [7:0] b0h_r [NUM_DEV];
   logic [7:0] b0l_r [NUM_DEV];
   logic [7:0] b1h_r [NUM_DEV];
   logic [7:0] b1l_r [NUM_DEV];
   logic [7:0] irq_r [NUM_DEV];
   logic [7:0] typ_r [NUM_DEV];
   logic [2:0] d0_r  [NUM_DEV];
   logic [2:0] d1_r  [NUM_DEV];
   logic [7:0] ven_r [NUM_DEV][VENDOR_REGS];
   logic [7:0] rd_nxt;
   logic       sw_rst;
   logic       bank_ok;
   logic       glob_hit;
   logic [2:0] gsel;
   logic [VW-1:0] vsel;

   assign bank_ok  = bank_r < 8'(NUM_DEV);
   assign glob_hit = index_r >= IDX_GLOBAL_ONE && index_r <= IDX_GLOBAL_LAST;
   assign gsel     = index_r[2:0];
   assign vsel     = VW'(index_r - IDX_VENDOR_MIN);
   // Writing the reset bit acts once and never sticks
   assign sw_rst   = dat_wr_i && index_r == IDX_GLOBAL_ONE
                     && wdata_i[SWRST_BIT];

   // Index and bank select
   always_ff @(posedge clk_i) begin
      if (!reset_n_i) begin
         index_r <= RST_INDEX;
         bank_r  <= RST_ZERO;
      end else begin
         if (idx_wr_i)
            index_r <= wdata_i;
         if (sw_rst)
            bank_r <= RST_ZERO;
         else if (dat_wr_i && index_r == IDX_BANK_SEL)
            bank_r <= wdata_i;
      end
   end

   // Global registers; the lock bit survives a software reset
   always_ff @(posedge clk_i) begin
      if (!reset_n_i) begin
         for (int g = 0; g < 8; g++)
            gcfg_r[g] <= RST_ZERO;
      end else if (sw_rst) begin
         for (int g = 0; g < 8; g++)
            gcfg_r[g] <= RST_ZERO;
         gcfg_r[0][LOCK_BIT] <= gcfg_r[0][LOCK_BIT];
      end else if (dat_wr_i && glob_hit && gsel != 3'h0) begin
         gcfg_r[gsel] <= wdata_i;
      end else if (dat_wr_i && glob_hit) begin
         // Lock only clears by hardware reset
         gcfg_r[0] <= {gcfg_r[0][LOCK_BIT] | wdata_i[LOCK_BIT],
                       wdata_i[6:2], 1'b0, wdata_i[0]};
      end
   end

   // One independent bank per logical device
   for (genvar d = 0; d < NUM_DEV; d++) begin : g_dev
      logic hit;
      logic keep;
      assign hit  = dat_wr_i && bank_ok && bank_r == 8'(d);
      // Wake-up unit bank is left alone by hardware reset
      assign keep = (d == WAKE_DEV);
      always_ff @(posedge clk_i) begin
         if ((!reset_n_i && !keep) || sw_rst) begin
            act_r[d] <= RST_ZERO;
            b0h_r[d] <= RST_ZERO;
            b0l_r[d] <= RST_ZERO;
            b1h_r[d] <= RST_ZERO;
            b1l_r[d] <= RST_ZERO;
            irq_r[d] <= RST_ZERO;
            typ_r[d] <= RST_ZERO;
            d0_r[d]  <= DMA_NONE;
            d1_r[d]  <= DMA_NONE;
            for (int v = 0; v < VENDOR_REGS; v++)
               ven_r[d][v] <= RST_ZERO;
         end else if (hit) begin
            case (index_r)
               IDX_ACTIVATE:   act_r[d] <= {7'h00, wdata_i[ACT_BIT]};
               IDX_IOB0_HI:    b0h_r[d] <= wdata_i;
               IDX_IOB0_LO:    b0l_r[d] <= wdata_i;
               IDX_IOB1_HI:    b1h_r[d] <= wdata_i;
               IDX_IOB1_LO:    b1l_r[d] <= wdata_i;
               IDX_IRQ_SEL:    irq_r[d] <= {3'h0, wdata_i[4:0]};
               IDX_IRQ_TYPE:   typ_r[d] <= {6'h00, wdata_i[1:0]};
               IDX_DMA_FIRST:  d0_r[d]  <= wdata_i[2:0];
               IDX_DMA_SECOND: d1_r[d]  <= wdata_i[2:0];
               default: begin
                  if (index_r >= IDX_VENDOR_MIN
                      && index_r <= IDX_VENDOR_MAX)
                     ven_r[d][vsel] <= wdata_i;
               end
            endcase
         end
      end

      // Resources other than interrupt type and polarity are only presented while the device is active
      always_ff @(posedge clk_i) begin
         if (!reset_n_i && !keep) begin
            res_o[d]       <= '0;
            clk_en_o[d]    <= 1'b0;
            pins_used_o[d] <= 1'b0;
         end else begin
            res_o[d].active    <= act_r[d][ACT_BIT];
            res_o[d].io_base0  <= act_r[d][ACT_BIT] ?
                                  {b0h_r[d], b0l_r[d]} : 16'h0000;
            res_o[d].io_base1  <= act_r[d][ACT_BIT] ?
                                  {b1h_r[d], b1l_r[d]} : 16'h0000;
            // Line zero is no selection, so it never attaches
            res_o[d].irq_line  <= act_r[d][ACT_BIT] ?
                                  irq_r[d][3:0] : 4'h0;
            res_o[d].irq_wake  <= act_r[d][ACT_BIT]
                                  && irq_r[d][WAKE_BIT]
                                  && irq_r[d][3:0] != 4'h0;
            res_o[d].irq_level <= typ_r[d][LEVEL_BIT];
            res_o[d].irq_high  <= typ_r[d][POL_BIT];
            // Reserved DMA codes map to no channel
            res_o[d].dma0      <= act_r[d][ACT_BIT] && d0_r[d] < DMA_NONE ?
                                  d0_r[d] : DMA_NONE;
            res_o[d].dma1      <= act_r[d][ACT_BIT] && d1_r[d] < DMA_NONE ?
                                  d1_r[d] : DMA_NONE;
            clk_en_o[d]        <= act_r[d][ACT_BIT];
            pins_used_o[d]     <= act_r[d][ACT_BIT];
         end
      end
   end

   // Read multiplexer
   always_comb begin
      rd_nxt = RST_ZERO;
      if (idx_rd_i) begin
         rd_nxt = index_r;
      end else if (index_r == IDX_BANK_SEL) begin
         rd_nxt = bank_r;
      end else if (glob_hit) begin
         rd_nxt = gsel == 3'h0 ? PART_ID : gcfg_r[gsel];
      end else if (index_r >= IDX_BANKED_MIN && !bank_ok) begin
         rd_nxt = (index_r == IDX_DMA_FIRST || index_r == IDX_DMA_SECOND)
                  ? RST_DMA : RST_ZERO;
      end else if (index_r >= IDX_BANKED_MIN) begin
         case (index_r)
            IDX_ACTIVATE:   rd_nxt = act_r[bank_r[3:0]];
            IDX_IOB0_HI:    rd_nxt = b0h_r[bank_r[3:0]];
            IDX_IOB0_LO:    rd_nxt = b0l_r[bank_r[3:0]];
            IDX_IOB1_HI:    rd_nxt = b1h_r[bank_r[3:0]];
            IDX_IOB1_LO:    rd_nxt = b1l_r[bank_r[3:0]];
            IDX_IRQ_SEL:    rd_nxt = irq_r[bank_r[3:0]];
            IDX_IRQ_TYPE:   rd_nxt = typ_r[bank_r[3:0]];
            IDX_DMA_FIRST:  rd_nxt = {5'h00, d0_r[bank_r[3:0]]};
            IDX_DMA_SECOND: rd_nxt = {5'h00, d1_r[bank_r[3:0]]};
            default: begin
               if (index_r >= IDX_VENDOR_MIN && index_r <= IDX_VENDOR_MAX)
                  rd_nxt = ven_r[bank_r[3:0]][vsel];
               else
                  rd_nxt = RST_ZERO;
            end
         endcase
      end
   end

   always_ff @(posedge clk_i) begin
      if (!reset_n_i) begin
         rdata_o  <= RST_ZERO;
         rvalid_o <= 1'b0;
      end else begin
         rvalid_o <= idx_rd_i || dat_rd_i;
         if (idx_rd_i || dat_rd_i)
            rdata_o <= rd_nxt;
      end
   end

   chk_dma_idle_read: assert property (@(posedge clk_i) disable iff (!reset_n_i)
      dat_rd_i && !idx_rd_i && !bank_ok && index_r == IDX_DMA_FIRST
      |=> rdata_o == RST_DMA && rvalid_o)
      else $error("Unmapped DMA select did not read 04h");

   // The host always idles between strobes, so check each half separately
   chk_index_back: assert property (@(posedge clk_i) disable iff (!reset_n_i)
      idx_rd_i |=> rdata_o == $past(index_r) && rvalid_o)
      else $error("Index port did not read back");

   chk_index_write: assert property (@(posedge clk_i) disable iff (!reset_n_i)
      idx_wr_i
      |=> index_r == $past(wdata_i))
      else $error("Index port write not taken");

   chk_sw_reset_act: assert property (@(posedge clk_i) disable iff (!reset_n_i)
      sw_rst |=> ##1 !clk_en_o[0] && !pins_used_o[0])
      else $error("Software reset left device active");

   chk_lock_kept: assert property (@(posedge clk_i) disable iff (!reset_n_i)
      sw_rst && gcfg_r[0][LOCK_BIT] |=> gcfg_r[0][LOCK_BIT])
      else $error("Lock bit lost on software reset");

   chk_inactive_res: assert property (@(posedge clk_i) disable iff (!reset_n_i)
      !act_r[0][ACT_BIT] ##1 !act_r[0][ACT_BIT]
      |-> res_o[0].io_base0 == 16'h0000 && res_o[0].dma0 == DMA_NONE)
      else $error("Inactive device exposes resources");

   chk_active_base: assert property (@(posedge clk_i) disable iff (!reset_n_i)
      act_r[0][ACT_BIT] && !sw_rst
      |=> res_o[0].io_base0 == $past({b0h_r[0], b0l_r[0]}))
      else $error("Base address not presented");

   chk_clock_follow: assert property (@(posedge clk_i) disable iff (!reset_n_i)
      1'b1 |=> clk_en_o[0] == $past(act_r[0][ACT_BIT]))
      else $error("Clock enable does not follow activation");

   chk_wake_needs_line: assert property (@(posedge clk_i)
      disable iff (!reset_n_i)
      res_o[0].irq_wake |-> res_o[0].irq_line != 4'h0)
      else $error("Wake enabled without a line");

   chk_bank_write: assert property (@(posedge clk_i) disable iff (!reset_n_i)
      dat_wr_i && index_r == IDX_BANK_SEL && !sw_rst
      |=> bank_r == $past(wdata_i))
      else $error("Bank select write not taken");

   chk_sw_bank_clear: assert property (@(posedge clk_i)
      disable iff (!reset_n_i)
      sw_rst
      |=> bank_r == RST_ZERO)
      else $error("Software reset left bank select set");

   chk_sw_clears_bank: assert property (@(posedge clk_i)
      disable iff (!reset_n_i)
      sw_rst
      |=> act_r[0] == RST_ZERO && d0_r[0] == DMA_NONE)
      else $error("Software reset left bank registers set");

   chk_read_valid: assert property (@(posedge clk_i) disable iff (!reset_n_i)
      idx_rd_i || dat_rd_i
      |=> rvalid_o)
      else $error("Read strobe gave no valid pulse");

   chk_valid_pulse: assert property (@(posedge clk_i) disable iff (!reset_n_i)
      !idx_rd_i && !dat_rd_i
      |=> !rvalid_o)
      else $error("Valid pulse without a read strobe");

   chk_rdata_hold: assert property (@(posedge clk_i) disable iff (!reset_n_i)
      !idx_rd_i && !dat_rd_i
      |=> $stable(rdata_o))
      else $error("Read data changed without a read");

   // Last bank stands in for every bank the host cannot reach
   chk_foreign_bank: assert property (@(posedge clk_i)
      disable iff (!reset_n_i)
      dat_wr_i && !bank_ok && !sw_rst
      |=> $stable(b0h_r[NUM_DEV-1]) && $stable(act_r[NUM_DEV-1]))
      else $error("Write to missing bank changed a register");

   chk_bank_isolated: assert property (@(posedge clk_i)
      disable iff (!reset_n_i)
      dat_wr_i && bank_r != RST_ZERO && !sw_rst
      |=> $stable(b0h_r[0]) && $stable(irq_r[0]))
      else $error("Write through another bank changed bank zero");

   chk_unmapped_zero: assert property (@(posedge clk_i)
      disable iff (!reset_n_i)
      dat_rd_i && bank_ok && index_r > IDX_ACTIVATE
      && index_r < IDX_IOB0_HI
      |=> rdata_o == RST_ZERO)
      else $error("Unmapped index did not read zero");

   chk_dma0_map: assert property (@(posedge clk_i) disable iff (!reset_n_i)
      1'b1
      |=> res_o[0].dma0 <= DMA_NONE)
      else $error("Reserved first DMA code presented");

   chk_dma1_map: assert property (@(posedge clk_i) disable iff (!reset_n_i)
      1'b1
      |=> res_o[0].dma1 <= DMA_NONE)
      else $error("Reserved second DMA code presented");

   chk_level_follow: assert property (@(posedge clk_i)
      disable iff (!reset_n_i)
      1'b1
      |=> res_o[0].irq_level == $past(typ_r[0][LEVEL_BIT]))
      else $error("Interrupt type does not follow register");

   chk_pol_follow: assert property (@(posedge clk_i) disable iff (!reset_n_i)
      1'b1
      |=> res_o[0].irq_high == $past(typ_r[0][POL_BIT]))
      else $error("Interrupt polarity does not follow register");

   chk_pins_follow: assert property (@(posedge clk_i) disable iff (!reset_n_i)
      1'b1
      |=> pins_used_o[0] == $past(act_r[0][ACT_BIT]))
      else $error("Pin use flag does not follow activation");

   chk_line_inactive: assert property (@(posedge clk_i)
      disable iff (!reset_n_i)
      !act_r[0][ACT_BIT]
      |=> res_o[0].irq_line == 4'h0 && !res_o[0].irq_wake)
      else $error("Inactive device exposes an interrupt line");
endmodule : pcb_bank
`default_nettype wire

// ### hdl/pcb_pkg.sv
// Purpose: Constants and types for the configuration register bank.
// Assumes: Eight-bit index/data access from the host interface.
// Notes:   Indices are the configuration index values of the bank.
package pcb_pkg;
   localparam logic [7:0] IDX_BANK_SEL    = 8'h07;
   localparam logic [7:0] IDX_GLOBAL_ONE  = 8'h20;
   localparam logic [7:0] IDX_GLOBAL_LAST = 8'h27;
   localparam logic [7:0] IDX_BANKED_MIN  = 8'h30;
   localparam logic [7:0] IDX_ACTIVATE    = 8'h30;
   localparam logic [7:0] IDX_IOB0_HI     = 8'h60;
   localparam logic [7:0] IDX_IOB0_LO     = 8'h61;
   localparam logic [7:0] IDX_IOB1_HI     = 8'h62;
   localparam logic [7:0] IDX_IOB1_LO     = 8'h63;
   localparam logic [7:0] IDX_IRQ_SEL     = 8'h70;
   localparam logic [7:0] IDX_IRQ_TYPE    = 8'h71;
   localparam logic [7:0] IDX_DMA_FIRST   = 8'h74;
   localparam logic [7:0] IDX_DMA_SECOND  = 8'h75;
   localparam logic [7:0] IDX_VENDOR_MIN  = 8'hf0;
   localparam logic [7:0] IDX_VENDOR_MAX  = 8'hfe;
   localparam int         VENDOR_REGS     = 15;
   localparam int         ACT_BIT         = 0;
   localparam int         WAKE_BIT        = 4;
   localparam int         LEVEL_BIT       = 0;
   localparam int         POL_BIT         = 1;
   localparam int         SWRST_BIT       = 1;
   localparam int         LOCK_BIT        = 7;
   localparam logic [7:0] RST_ZERO        = 8'h00;
   localparam logic [2:0] DMA_NONE        = 3'h4;
   localparam logic [7:0] RST_DMA         = 8'h04;
   localparam logic [7:0] RST_INDEX       = 8'h00;
   localparam logic [7:0] ID_DEFAULT      = 8'h5a;

   typedef struct packed {
      logic [15:0] io_base0;
      logic [15:0] io_base1;
      logic [3:0]  irq_line;
      logic        irq_wake;
      logic        irq_level;
      logic        irq_high;
      logic [2:0]  dma0;
      logic [2:0]  dma1;
      logic        active;
   } pcb_res_t;
endpackage : pcb_pkg
